// >>> hdl/idbs_consts.vh
// Purpose: Shared constants of the inverting driver with boundary scan.
// Assumes: Included by its bare name from every design file that needs it.
// Notes:   Bit positions count from the end of the chain nearest test data out.
`ifndef IDBS_CONSTS_VH
`define IDBS_CONSTS_VH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define IDBS_BYTE_W        9
`define IDBS_IR_W          8
`define IDBS_PSC_LEN       42
`define IDBS_STATE_W       16

// ----------------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------------
`define IDBS_OP_EXTEST     8'h00
`define IDBS_OP_SAMPLE     8'h81
`define IDBS_OP_CLAMP      8'h82
`define IDBS_OP_HIGHZ      8'h03
`define IDBS_OP_BYPASS     8'hff

// Capture pattern: low bits 01, upper six bits are an arbitrary pseudo identifier.
`define IDBS_IR_CAPTURE    8'hb5

// ----------------------------------------------------------------------------
// Boundary chain positions
// ----------------------------------------------------------------------------
`define IDBS_BIT_A_EN1     41
`define IDBS_BIT_A_EN2     40
`define IDBS_BIT_A_COMB    39
`define IDBS_BIT_B_EN1     38
`define IDBS_BIT_B_EN2     37
`define IDBS_BIT_B_COMB    36
`define IDBS_A_IN_HI       35
`define IDBS_A_IN_LO       27
`define IDBS_B_IN_HI       26
`define IDBS_B_IN_LO       18
`define IDBS_A_OUT_HI      17
`define IDBS_A_OUT_LO      9
`define IDBS_B_OUT_HI      8
`define IDBS_B_OUT_LO      0

// ----------------------------------------------------------------------------
// One-hot controller state indices
// ----------------------------------------------------------------------------
`define IDBS_S_TLR         0
`define IDBS_S_RTI         1
`define IDBS_S_SEL_DR      2
`define IDBS_S_CAP_DR      3
`define IDBS_S_SHF_DR      4
`define IDBS_S_EX1_DR      5
`define IDBS_S_PAU_DR      6
`define IDBS_S_EX2_DR      7
`define IDBS_S_UPD_DR      8
`define IDBS_S_SEL_IR      9
`define IDBS_S_CAP_IR      10
`define IDBS_S_SHF_IR      11
`define IDBS_S_EX1_IR      12
`define IDBS_S_PAU_IR      13
`define IDBS_S_EX2_IR      14
`define IDBS_S_UPD_IR      15

`endif

// >>> hdl/idbs_sync.v
// Purpose: Two-stage synchroniser for a group of pin inputs.
// Assumes: Each bit is an independent level from outside the clock domain.
// Notes:   The first stage is read only by the second stage.
//          No reset: the stages keep sampling, so pin levels are ready when reset ends.
`timescale 1ns/1ps

module idbs_sync
#(
  parameter WIDTH = 1
)
(
  input  wire             clock,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;

  // --------------------------------------------------------------------------
  // Synchroniser stages
  // --------------------------------------------------------------------------
  always @(posedge clock)
  begin
    stage1_r <= async_in;
    stage2_r <= stage1_r;
  end

  assign sync_out = stage2_r;

endmodule // idbs_sync

// >>> hdl/idbs_tap_fsm.v
// Purpose: Sixteen-state test access controller.
// Assumes: step pulses once per rising test clock edge; tms is sampled with it.
// Notes:   Five steps with tms high reach the logic reset state from anywhere.
`timescale 1ns/1ps
`include "idbs_consts.vh"

module idbs_tap_fsm
(
  input  wire                     clock,
  input  wire                     reset_n,
  input  wire                     step,
  input  wire                     tms,
  output wire [`IDBS_STATE_W-1:0] state
);

  localparam [15:0] S_TLR    = 16'h0001;
  localparam [15:0] S_RTI    = 16'h0002;
  localparam [15:0] S_SEL_DR = 16'h0004;
  localparam [15:0] S_CAP_DR = 16'h0008;
  localparam [15:0] S_SHF_DR = 16'h0010;
  localparam [15:0] S_EX1_DR = 16'h0020;
  localparam [15:0] S_PAU_DR = 16'h0040;
  localparam [15:0] S_EX2_DR = 16'h0080;
  localparam [15:0] S_UPD_DR = 16'h0100;
  localparam [15:0] S_SEL_IR = 16'h0200;
  localparam [15:0] S_CAP_IR = 16'h0400;
  localparam [15:0] S_SHF_IR = 16'h0800;
  localparam [15:0] S_EX1_IR = 16'h1000;
  localparam [15:0] S_PAU_IR = 16'h2000;
  localparam [15:0] S_EX2_IR = 16'h4000;
  localparam [15:0] S_UPD_IR = 16'h8000;

  reg [15:0] state_r;
  reg [15:0] state_nxt;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always @*
  begin
    case (state_r)
      S_TLR:    state_nxt = tms ? S_TLR    : S_RTI;
      S_RTI:    state_nxt = tms ? S_SEL_DR : S_RTI;
      S_SEL_DR: state_nxt = tms ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: state_nxt = tms ? S_EX1_DR : S_SHF_DR;
      S_SHF_DR: state_nxt = tms ? S_EX1_DR : S_SHF_DR;
      S_EX1_DR: state_nxt = tms ? S_UPD_DR : S_PAU_DR;
      S_PAU_DR: state_nxt = tms ? S_EX2_DR : S_PAU_DR;
      S_EX2_DR: state_nxt = tms ? S_UPD_DR : S_SHF_DR;
      S_UPD_DR: state_nxt = tms ? S_SEL_DR : S_RTI;
      S_SEL_IR: state_nxt = tms ? S_TLR    : S_CAP_IR;
      S_CAP_IR: state_nxt = tms ? S_EX1_IR : S_SHF_IR;
      S_SHF_IR: state_nxt = tms ? S_EX1_IR : S_SHF_IR;
      S_EX1_IR: state_nxt = tms ? S_UPD_IR : S_PAU_IR;
      S_PAU_IR: state_nxt = tms ? S_EX2_IR : S_PAU_IR;
      S_EX2_IR: state_nxt = tms ? S_UPD_IR : S_SHF_IR;
      S_UPD_IR: state_nxt = tms ? S_SEL_DR : S_RTI;
      default:  state_nxt = S_TLR;
    endcase
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!reset_n)
      state_r <= S_TLR;
    else if (step)
      state_r <= state_nxt;
  end

  assign state = state_r;

endmodule // idbs_tap_fsm

// >>> hdl/idbs_top.v
// Purpose: Two inverting tri-state driver bytes with boundary-scan test logic.
// Assumes: Test clock, mode select, data in and all system pins are sampled here.
// Notes:   Output enables are high while a byte drives its pins.
//
// Contract
// - Two independent nine-bit bytes A and B, each with own buses and enables.
// - Both enables low makes each output the inverse of its input.
// - Either enable of a byte high floats all nine outputs of that byte.
// - Test port has data in, data out, mode select and test clock.
// - Every system input has an observe-only cell that captures without override.
// - Every system output has a cell that captures or substitutes its update value.
// - Each internal combined byte enable has a controllable cell.
// - Internal A enable gates A outputs, internal B enable gates B outputs.
// - A controlled internal enable of one drives its byte, zero floats it.
// - Bypass is a one-bit stage that captures zero.
// - Instruction register is eight bits and captures pattern ending in 01.
// - No identification register; the capture pattern identifies the part.
// - Code 00 selects EXTEST, code 81 selects SAMPLE/PRELOAD.
// - Code 82 selects CLAMP, code 03 HIGH-Z, every other code BYPASS.
// - Boundary chain is exactly 42 cells long.
// - Bits 41 to 36 hold A enables, internal A, B enables, internal B.
// - A inputs sit at bits 35 to 27, B inputs at 26 to 18.
// - A outputs at 17 to 9, B outputs at 8 to 0 nearest data out.
`timescale 1ns/1ps
`include "idbs_consts.vh"

module idbs_top
(
  input  wire       clock,
  input  wire       reset_n,
  input  wire       tck,
  input  wire       tms,
  input  wire       tdi,
  output wire       tdo,
  output wire       tdo_oe,
  input  wire [8:0] a_byte_data_in,
  input  wire [8:0] b_byte_data_in,
  input  wire       a_enable_low_first,
  input  wire       a_enable_low_second,
  input  wire       b_enable_low_first,
  input  wire       b_enable_low_second,
  output wire [8:0] a_byte_data_out,
  output wire       a_byte_data_oe,
  output wire [8:0] b_byte_data_out,
  output wire       b_byte_data_oe
);

  localparam SYNC_W = 25;

  wire [SYNC_W-1:0]         sync_bus;
  wire                      tck_s;
  wire                      tms_s;
  wire                      tdi_s;
  wire [8:0]                a_in_s;
  wire [8:0]                b_in_s;
  wire                      a_en1_s;
  wire                      a_en2_s;
  wire                      b_en1_s;
  wire                      b_en2_s;
  wire [`IDBS_STATE_W-1:0]  tap_state;
  wire                      tck_rise;
  wire                      tck_fall;
  wire                      st_tlr;
  wire                      st_cap_dr;
  wire                      st_shf_dr;
  wire                      st_upd_dr;
  wire                      st_cap_ir;
  wire                      st_shf_ir;
  wire                      st_upd_ir;
  wire                      a_comb_sys;
  wire                      b_comb_sys;
  wire [8:0]                a_out_sys;
  wire [8:0]                b_out_sys;
  wire                      sel_psc;
  wire                      drive_test;
  wire                      force_float;
  wire [`IDBS_PSC_LEN-1:0]  psc_cap;

  reg                       tck_d_r;
  reg  [`IDBS_IR_W-1:0]     ir_shift_r;
  reg  [`IDBS_IR_W-1:0]     ir_latch_r;
  reg                       bypass_r;
  reg  [`IDBS_PSC_LEN-1:0]  psc_shift_r;
  reg  [`IDBS_PSC_LEN-1:0]  psc_upd_r;
  reg                       tdo_r;
  reg                       tdo_oe_r;
  reg  [8:0]                a_out_r;
  reg                       a_oe_r;
  reg  [8:0]                b_out_r;
  reg                       b_oe_r;
  reg  [8:0]                a_out_nxt;
  reg                       a_oe_nxt;
  reg  [8:0]                b_out_nxt;
  reg                       b_oe_nxt;
  reg                       is_extest;
  reg                       is_sample;
  reg                       is_clamp;
  reg                       is_highz;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Puts bit 0 of a byte at the high end of its chain slice.
  function [8:0] rev9;
    input [8:0] x;
    integer i;
    begin
      for (i = 0; i < 9; i = i + 1)
        rev9[8-i] = x[i];
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  idbs_sync #(.WIDTH(SYNC_W)) u_sync
  (
    .clock    (clock),
    .async_in ({tck, tms, tdi, a_byte_data_in, b_byte_data_in,
                a_enable_low_first, a_enable_low_second,
                b_enable_low_first, b_enable_low_second}),
    .sync_out (sync_bus)
  );

  assign tck_s   = sync_bus[24];
  assign tms_s   = sync_bus[23];
  assign tdi_s   = sync_bus[22];
  assign a_in_s  = sync_bus[21:13];
  assign b_in_s  = sync_bus[12:4];
  assign a_en1_s = sync_bus[3];
  assign a_en2_s = sync_bus[2];
  assign b_en1_s = sync_bus[1];
  assign b_en2_s = sync_bus[0];

  // --------------------------------------------------------------------------
  // Test clock edges
  // --------------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!reset_n)
      tck_d_r <= 1'b0;
    else
      tck_d_r <= tck_s;
  end

  assign tck_rise = tck_s & ~tck_d_r;
  assign tck_fall = ~tck_s & tck_d_r;

  // --------------------------------------------------------------------------
  // Test access controller
  // --------------------------------------------------------------------------
  idbs_tap_fsm u_tap
  (
    .clock   (clock),
    .reset_n (reset_n),
    .step    (tck_rise),
    .tms     (tms_s),
    .state   (tap_state)
  );

  assign st_tlr    = tap_state[`IDBS_S_TLR];
  assign st_cap_dr = tap_state[`IDBS_S_CAP_DR];
  assign st_shf_dr = tap_state[`IDBS_S_SHF_DR];
  assign st_upd_dr = tap_state[`IDBS_S_UPD_DR];
  assign st_cap_ir = tap_state[`IDBS_S_CAP_IR];
  assign st_shf_ir = tap_state[`IDBS_S_SHF_IR];
  assign st_upd_ir = tap_state[`IDBS_S_UPD_IR];

  // --------------------------------------------------------------------------
  // Instruction decode
  // --------------------------------------------------------------------------
  always @*
  begin
    is_extest = 1'b0;
    is_sample = 1'b0;
    is_clamp  = 1'b0;
    is_highz  = 1'b0;
    case (ir_latch_r)
      `IDBS_OP_EXTEST: is_extest = 1'b1;
      `IDBS_OP_SAMPLE: is_sample = 1'b1;
      `IDBS_OP_CLAMP:  is_clamp  = 1'b1;
      `IDBS_OP_HIGHZ:  is_highz  = 1'b1;
      default:         is_highz  = 1'b0;
    endcase
  end

  // Only EXTEST and SAMPLE/PRELOAD put the boundary chain between the test pins.
  assign sel_psc     = is_extest | is_sample;
  assign drive_test  = is_extest | is_clamp;
  assign force_float = is_highz;

  // --------------------------------------------------------------------------
  // Instruction register
  // --------------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      ir_shift_r <= `IDBS_OP_BYPASS;
      ir_latch_r <= `IDBS_OP_BYPASS;
    end
    else
    begin
      if (tck_rise && st_cap_ir)
        ir_shift_r <= `IDBS_IR_CAPTURE;
      else if (tck_rise && st_shf_ir)
        ir_shift_r <= {tdi_s, ir_shift_r[`IDBS_IR_W-1:1]};
      if (tck_fall && st_tlr)
        ir_latch_r <= `IDBS_OP_BYPASS;
      else if (tck_fall && st_upd_ir)
        ir_latch_r <= ir_shift_r;
    end
  end

  // --------------------------------------------------------------------------
  // Bypass stage
  // --------------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!reset_n)
      bypass_r <= 1'b0;
    else if (tck_rise && st_cap_dr && !sel_psc)
      bypass_r <= 1'b0;
    else if (tck_rise && st_shf_dr && !sel_psc)
      bypass_r <= tdi_s;
  end

  // --------------------------------------------------------------------------
  // System path
  // --------------------------------------------------------------------------
  assign a_comb_sys = ~(a_en1_s | a_en2_s);
  assign b_comb_sys = ~(b_en1_s | b_en2_s);
  assign a_out_sys  = ~a_in_s;
  assign b_out_sys  = ~b_in_s;

  // --------------------------------------------------------------------------
  // Boundary chain
  // --------------------------------------------------------------------------
  // Inputs are observed only; outputs and combined enables capture system values.
  assign psc_cap = {a_en1_s, a_en2_s, a_comb_sys,
                    b_en1_s, b_en2_s, b_comb_sys,
                    rev9(a_in_s), rev9(b_in_s),
                    rev9(a_out_sys), rev9(b_out_sys)};

  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      psc_shift_r <= {`IDBS_PSC_LEN{1'b0}};
      psc_upd_r   <= {`IDBS_PSC_LEN{1'b0}};
    end
    else
    begin
      if (tck_rise && st_cap_dr && sel_psc)
        psc_shift_r <= psc_cap;
      else if (tck_rise && st_shf_dr && sel_psc)
        psc_shift_r <= {tdi_s, psc_shift_r[`IDBS_PSC_LEN-1:1]};
      if (tck_fall && st_upd_dr && sel_psc)
        psc_upd_r <= psc_shift_r;
    end
  end

  // --------------------------------------------------------------------------
  // Test data out
  // --------------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_oe_r <= st_shf_ir | st_shf_dr;
      if (st_shf_ir)
        tdo_r <= ir_shift_r[0];
      else if (sel_psc)
        tdo_r <= psc_shift_r[0];
      else
        tdo_r <= bypass_r;
    end
  end

  assign tdo    = tdo_r;
  assign tdo_oe = tdo_oe_r;

  // --------------------------------------------------------------------------
  // Output drivers
  // --------------------------------------------------------------------------
  always @*
  begin
    a_out_nxt = a_out_sys;
    b_out_nxt = b_out_sys;
    a_oe_nxt  = a_comb_sys;
    b_oe_nxt  = b_comb_sys;
    if (force_float)
    begin
      a_oe_nxt = 1'b0;
      b_oe_nxt = 1'b0;
    end
    else if (drive_test)
    begin
      a_out_nxt = rev9(psc_upd_r[`IDBS_A_OUT_HI:`IDBS_A_OUT_LO]);
      b_out_nxt = rev9(psc_upd_r[`IDBS_B_OUT_HI:`IDBS_B_OUT_LO]);
      a_oe_nxt  = psc_upd_r[`IDBS_BIT_A_COMB];
      b_oe_nxt  = psc_upd_r[`IDBS_BIT_B_COMB];
    end
  end

  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      a_out_r <= 9'h000;
      b_out_r <= 9'h000;
      a_oe_r  <= 1'b0;
      b_oe_r  <= 1'b0;
    end
    else
    begin
      a_out_r <= a_out_nxt;
      b_out_r <= b_out_nxt;
      a_oe_r  <= a_oe_nxt;
      b_oe_r  <= b_oe_nxt;
    end
  end

  assign a_byte_data_out = a_out_r;
  assign a_byte_data_oe  = a_oe_r;
  assign b_byte_data_out = b_out_r;
  assign b_byte_data_oe  = b_oe_r;

endmodule // idbs_top

// >>> bench/idbs_top_checker.sv
// Purpose: Port-level checks of the inverting driver with boundary scan.
// Assumes: With the test clock idle since reset the plain driver path is in force.
// Notes:   Pin history is kept in short shift registers.
`timescale 1ns/1ps

module idbs_top_checker
(
  input wire       clock,
  input wire       reset_n,
  input wire       tck,
  input wire       tms,
  input wire       tdi,
  input wire       tdo,
  input wire       tdo_oe,
  input wire [8:0] a_byte_data_in,
  input wire [8:0] b_byte_data_in,
  input wire       a_enable_low_first,
  input wire       a_enable_low_second,
  input wire       b_enable_low_first,
  input wire       b_enable_low_second,
  input wire [8:0] a_byte_data_out,
  input wire       a_byte_data_oe,
  input wire [8:0] b_byte_data_out,
  input wire       b_byte_data_oe
);
  reg  [10:0] ap1_r, ap2_r, ap3_r, ap4_r;
  reg  [10:0] bp1_r, bp2_r, bp3_r, bp4_r;
  reg  [2:0]  cnt_r;
  reg         tck_seen_r;
  wire        idle   = cnt_r == 3'h7 && !tck_seen_r;
  wire [10:0] ap     = {a_enable_low_first, a_enable_low_second, a_byte_data_in};
  wire [10:0] bp     = {b_enable_low_first, b_enable_low_second, b_byte_data_in};
  wire        a_calm = idle && ap2_r == ap3_r && ap3_r == ap4_r;
  wire        b_calm = idle && bp2_r == bp3_r && bp3_r == bp4_r;

  always @(posedge clock)
  begin
    {ap4_r, ap3_r, ap2_r, ap1_r} <= {ap3_r, ap2_r, ap1_r, ap};
    {bp4_r, bp3_r, bp2_r, bp1_r} <= {bp3_r, bp2_r, bp1_r, bp};
    if (!reset_n)
    begin
      cnt_r      <= 3'h0;
      tck_seen_r <= 1'b0;
    end
    else
    begin
      cnt_r      <= cnt_r + {2'h0, cnt_r != 3'h7};
      tck_seen_r <= tck_seen_r | tck;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_reset_quiet: assert property (!$past(reset_n) |-> !tdo && !tdo_oe && !a_byte_data_oe
    && !b_byte_data_oe && a_byte_data_out == 9'h0) else $error("outputs not cleared by reset");
  a_a_enable_gate: assert property (a_calm |-> a_byte_data_oe == !(ap3_r[10] | ap3_r[9]))
    else $error("A enable mismatch");
  a_b_enable_gate: assert property (b_calm |-> b_byte_data_oe == !(bp3_r[10] | bp3_r[9]))
    else $error("B enable mismatch");
  a_a_invert: assert property (a_calm && ap3_r[10:9] == 2'h0 |-> a_byte_data_out == ~ap3_r[8:0])
    else $error("A data not inverted");
  a_b_invert: assert property (b_calm && bp3_r[10:9] == 2'h0 |-> b_byte_data_out == ~bp3_r[8:0])
    else $error("B data not inverted");
  a_a_hold_still: assert property (a_calm && ap == ap1_r && ap1_r == ap2_r |->
    $stable(a_byte_data_out) && $stable(a_byte_data_oe)) else $error("A moved with own pins still");
  a_tdo_on_fall: assert property ($changed(tdo) |-> !$past(tck, 2) && !$past(tck, 3))
    else $error("tdo changed off a falling test clock");
  a_tdo_oe_fall: assert property ($changed(tdo_oe) |-> !$past(tck, 2) && !$past(tck, 3))
    else $error("tdo_oe changed off a falling test clock");
  a_port_quiet: assert property (idle |-> !tdo_oe)
    else $error("tdo driven without shifting");
  a_wake_no_drive: assert property (!tck_seen_r |-> (!a_byte_data_oe || ap3_r[10:9] == 2'h0)
    && (!b_byte_data_oe || bp3_r[10:9] == 2'h0)) else $error("byte driven with an enable high");
endmodule // idbs_top_checker

bind idbs_top idbs_top_checker idbs_top_checker_inst
(
  .clock(clock), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
  .tdo_oe(tdo_oe), .a_byte_data_in(a_byte_data_in), .b_byte_data_in(b_byte_data_in),
  .a_enable_low_first(a_enable_low_first), .a_enable_low_second(a_enable_low_second),
  .b_enable_low_first(b_enable_low_first), .b_enable_low_second(b_enable_low_second),
  .a_byte_data_out(a_byte_data_out), .a_byte_data_oe(a_byte_data_oe),
  .b_byte_data_out(b_byte_data_out), .b_byte_data_oe(b_byte_data_oe)
);

// >>> bench/idbs_jtag_host.sv
// Purpose: Test controller on the far side of the test port.
// Assumes: Called at a falling bench clock edge; one test clock period is eight clocks.
// Notes:   The test clock stands low between frames and tdi toggles outside shifts.
`timescale 1ns/1ps

module idbs_jtag_host
(
  input  wire  clock,
  input  wire  tdo,
  input  wire  tdo_oe,
  output logic tck,
  output logic tms,
  output logic tdi
);
  logic bit_seen;

  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One period: mode and data set while low, tdo read just before the rise.
  task automatic pulse(input logic m, input logic d);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clock);
    bit_seen = tdo_oe ? tdo : 1'bx;
    tck = 1'b1;
    repeat (4) @(negedge clock);
    tck = 1'b0;
  endtask

  // Five high mode selects reach logic reset, then one low goes to idle.
  task automatic to_idle();
    repeat (5) pulse(1'b1, ~tdi);
    pulse(1'b0, ~tdi);
  endtask

  // Scan from idle back to idle; the value leaves least significant bit first.
  task automatic scan(input logic ir, input logic [63:0] din, input int n,
                      output logic [63:0] dout);
    dout = 64'h0;
    pulse(1'b1, ~tdi);
    if (ir)
      pulse(1'b1, ~tdi);
    pulse(1'b0, ~tdi);
    pulse(1'b0, ~tdi);
    for (int k = 0; k < n; k++)
    begin
      pulse(k == n - 1, din[k]);
      dout[k] = bit_seen;
    end
    pulse(1'b1, ~tdi);
    pulse(1'b0, ~tdi);
  endtask
endmodule // idbs_jtag_host

// >>> bench/idbs_top_bench.sv
// Purpose: Self-checking bench of the inverting driver with boundary scan.
// Assumes: Pins and the test port change on the falling clock edge.
// Notes:   Expected values go into a queue that a monitor process compares.
`timescale 1ns/1ps
`include "idbs_consts.vh"

module idbs_top_bench;
  logic        clock   = 1'b0;
  logic        reset_n = 1'b0;
  wire         tck, tms, tdi, tdo, tdo_oe, a_oe, b_oe;
  wire  [8:0]  a_out, b_out;
  logic [8:0]  a_in    = 9'h0;
  logic [8:0]  b_in    = 9'h0;
  logic [3:0]  en      = 4'hf;
  logic [63:0] note_q [$];
  logic [63:0] seen_v, tout, m;
  logic [41:0] pv;
  logic [15:0] seed    = 16'h7b45;
  logic [8:0]  ra, rb, pa, pb;
  logic [7:0]  codes [5] = '{8'h01, 8'h80, 8'h83, 8'hfe, 8'hff};
  event        seen_e;
  int          bad_count = 0;
  int          n_checks  = 0;
  int          i;
  int          j;

  always #25 clock = ~clock;

  idbs_top idbs_top_inst
  (
    .clock(clock), .reset_n(reset_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .a_byte_data_in(a_in), .b_byte_data_in(b_in),
    .a_enable_low_first(en[3]), .a_enable_low_second(en[2]),
    .b_enable_low_first(en[1]), .b_enable_low_second(en[0]),
    .a_byte_data_out(a_out), .a_byte_data_oe(a_oe), .b_byte_data_out(b_out),
    .b_byte_data_oe(b_oe)
  );
  idbs_jtag_host idbs_jtag_host_inst
  (
    .clock(clock), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi)
  );

  function automatic logic [8:0] rev9(input logic [8:0] v);
    for (int k = 0; k < 9; k++)
      rev9[k] = v[8 - k];
  endfunction
  function automatic logic [63:0] sys(input logic ao, input logic [8:0] av,
                                      input logic bo, input logic [8:0] bv);
    return {44'h0, ao, ao ? av : 9'h0, bo, bo ? bv : 9'h0};
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic expect_now(input logic [63:0] exp, input logic [63:0] seen);
    note_q.push_back(exp);
    seen_v = seen;
    ->seen_e;
    @(negedge clock);
  endtask
  always @(seen_e)
    check(seen_v, note_q.pop_front());

  task automatic sys_chk(input logic ao, input logic [8:0] av, input logic bo,
                         input logic [8:0] bv);
    expect_now(sys(ao, av, bo, bv), sys(a_oe, a_out, b_oe, b_out));
  endtask
  function automatic void rnd(output logic [8:0] v);
    repeat (9) seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    v = seed[8:0];
  endfunction
  task automatic pins(input logic [3:0] e, input logic [8:0] a, input logic [8:0] b);
    en   = e;
    a_in = a;
    b_in = b;
    repeat (6) @(negedge clock);
  endtask
  task automatic ir_load(input logic [7:0] code);
    idbs_jtag_host_inst.scan(1'b1, {56'h0, code}, 8, tout);
    expect_now({56'h0, `IDBS_IR_CAPTURE}, tout);
  endtask
  task automatic by_scan();
    idbs_jtag_host_inst.scan(1'b0, 64'h5, 4, tout);
    expect_now(64'ha, tout);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge clock);
    bad_count++;
    stop_test();
  end

  initial
  begin
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    for (i = 0; i < 16; i++)
    begin
      rnd(ra);
      rnd(rb);
      pins(i[3:0], ra, rb);
      sys_chk(!(i[3] | i[2]), ~ra, !(i[1] | i[0]), ~rb);
    end
    idbs_jtag_host_inst.to_idle();
    for (j = 0; j < 5; j++)
    begin
      ir_load(codes[j]);
      by_scan();
    end
    rnd(ra);
    rnd(rb);
    rnd(pa);
    rnd(pb);
    pins(4'b0001, ra, rb);
    ir_load(`IDBS_OP_SAMPLE);
    pv = {6'h3f, 18'h0, pa, pb};
    idbs_jtag_host_inst.scan(1'b0, {14'h0, pv, 8'h3c}, 50, tout);
    expect_now({14'h0, 8'h3c, 6'b001010, rev9(ra), rev9(rb), rev9(~ra), rev9(~rb)}, tout);
    sys_chk(1'b1, ~ra, 1'b0, ~rb);
    pins(4'b1100, ra, rb);
    ir_load(`IDBS_OP_EXTEST);
    sys_chk(1'b1, rev9(pa), 1'b1, rev9(pb));
    m = {22'h0, 2'h3, 1'b0, 2'h3, 1'b0, 18'h3ffff, 18'h0};
    for (j = 0; j < 2; j++)
    begin
      rnd(pa);
      rnd(pb);
      pv = {2'h0, j == 0, 2'h0, j == 1, 18'h0, pa, pb};
      idbs_jtag_host_inst.scan(1'b0, {22'h0, pv}, 42, tout);
      expect_now({22'h0, 6'b110000, rev9(ra), rev9(rb), 18'h0} & m, tout & m);
      sys_chk(j == 0, rev9(pa), j == 1, rev9(pb));
    end
    ir_load(`IDBS_OP_CLAMP);
    by_scan();
    sys_chk(1'b0, rev9(pa), 1'b1, rev9(pb));
    ir_load(`IDBS_OP_HIGHZ);
    sys_chk(1'b0, 9'h0, 1'b0, 9'h0);
    by_scan();
    idbs_jtag_host_inst.to_idle();
    sys_chk(1'b0, ~ra, 1'b1, ~rb);
    ir_load(`IDBS_OP_EXTEST);
    reset_n = 1'b0;
    repeat (3) @(negedge clock);
    reset_n = 1'b1;
    pins(4'b0000, ~ra, rb);
    sys_chk(1'b1, ra, 1'b1, ~rb);
    stop_test();
  end
endmodule // idbs_top_bench
